// *** verilog/edge_color_pkg.sv ***
// package: register map, field layout, constants and pixel type of the edge/false colour slice
package edge_color_pkg;

    // ----------------------------------------------------------------
    // register byte offsets on the apb bus
    // ----------------------------------------------------------------
    localparam logic [7:0] edge_enhancer_enable_off        = 8'h00;
    localparam logic [7:0] median_noise_reduce_enable_off  = 8'h04;
    localparam logic [7:0] highpass_shift_length_off       = 8'h08;
    localparam logic [7:0] highpass_coef_r0c0_off          = 8'h0c; // r0c0..r2c2 follow, one word each
    localparam logic [7:0] false_color_suppress_enable_off = 8'h30;
    localparam logic [7:0] suppress_detector_type_off      = 8'h34;
    localparam int         coef_count                      = 9;

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int          enable_bit      = 0;
    localparam int          shift_width     = 4;
    localparam int          coef_width      = 10;
    localparam int          type_width      = 3;
    localparam logic        enable_reset    = 1'b0;
    localparam logic [3:0]  shift_reset     = 4'h0;
    localparam logic [9:0]  coef_reset      = 10'h000;
    localparam logic [2:0]  type_reset      = 3'h0;
    localparam logic [7:0]  chroma_neutral  = 8'h80;
    localparam logic [7:0]  luma_max        = 8'hff;

    // ----------------------------------------------------------------
    // detector source selection
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        det_luma      = 3'h0,
        det_horiz_hpf = 3'h1,
        det_vert_hpf  = 3'h2,
        det_2d_hpf    = 3'h3,
        det_edge_hpf  = 3'h4
    } detector_type;

    // one pixel: luminance and two chroma samples
    typedef struct packed {
        logic [7:0] y;
        logic [7:0] cb;
        logic [7:0] cr;
    } pixel_type;

endpackage

// *** verilog/edge_color_filter.sv ***
// edge enhancer, median noise reducer and false colour suppression with apb configuration
//
// Overview of operation
// - luminance gets the high-pass edge term added only while the enhancer enable bit is 1, otherwise it passes.
// - the horizontal 3-tap median noise reducer acts only while its enable bit 0 is 1.
// - the edge high-pass result is shifted right by a 4-bit amount 0..15 held in bits 3..0.
// - the nine kernel coefficients, rows and columns 0..2, are 10-bit signed integers in bits 9..0.
// - chroma is suppressed only while the suppression enable bit is 1, otherwise it passes unchanged.
// - a 3-bit type picks the detector: 0 luma, 1 horizontal, 2 vertical, 3 2d, 4 the edge enhancer 2d high-pass.
`timescale 1ns/1ns

// ----------------------------------------------------------------
// fifo with registered valid and ready
// ----------------------------------------------------------------
module stream_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [WIDTH-1:0]         in_data,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [WIDTH-1:0]              out_data,
    output logic [$clog2(DEPTH+1)-1:0]    level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [LW-1:0]    level_reg;
    logic [LW-1:0]    level_next;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign level     = level_reg;
    assign out_data  = mem[rd_ptr_reg];

    // occupancy after this cycle's push and pop
    always_comb begin
        level_next = level_reg;
        if (push && !pop) begin
            level_next = level_reg + LW'(1);
        end else if (pop && !push) begin
            level_next = level_reg - LW'(1);
        end
    end

    // pointers, level and the registered full/empty flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            level_reg  <= '0;
            in_ready   <= 1'b1;
            out_valid  <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
            end
            level_reg <= level_next;
            in_ready  <= level_next != LW'(DEPTH);
            out_valid <= level_next != '0;
        end
    end

    // storage needs no reset
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end
endmodule

// ----------------------------------------------------------------
// top: configuration registers and the pixel path
// ----------------------------------------------------------------
module edge_color_filter #(
    parameter int         LINE_WIDTH     = 64,
    parameter int         FIFO_DEPTH     = 16,
    parameter logic [8:0] SUPPRESS_LEVEL = 9'h040
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        pix_in_valid,
    output logic                             pix_in_ready,
    input  wire edge_color_pkg::pixel_type   pix_in,
    output logic                             pix_out_valid,
    input  wire logic                        pix_out_ready,
    output edge_color_pkg::pixel_type        pix_out
);
    localparam int CW = $clog2(LINE_WIDTH);
    localparam int LW = $clog2(FIFO_DEPTH+1);

    logic                     edge_enable_reg;
    logic                     median_enable_reg;
    logic [3:0]               shift_reg;
    logic signed [9:0]        coef_reg [0:edge_color_pkg::coef_count-1];
    logic                     suppress_enable_reg;
    logic [2:0]               det_type_reg;

    logic                     access;
    logic                     wr_en;
    logic [31:0]              rd_value;
    logic                     addr_hit;
    logic [7:0]               coef_off;
    logic [3:0]               coef_idx;

    // ----------------------------------------------------------------
    // apb slave: one wait state, pready from a flop
    // ----------------------------------------------------------------
    assign access   = psel && penable;
    assign wr_en    = access && pready && pwrite;
    assign coef_off = paddr - edge_color_pkg::highpass_coef_r0c0_off;
    assign coef_idx = coef_off[5:2];

    // read mux; reserved bits read zero, unmapped answers with pslverr
    always_comb begin
        rd_value = '0;
        addr_hit = 1'b1;
        if (paddr[1:0] != 2'b00) begin
            addr_hit = 1'b0;
        end else if (paddr == edge_color_pkg::edge_enhancer_enable_off) begin
            rd_value[edge_color_pkg::enable_bit] = edge_enable_reg;
        end else if (paddr == edge_color_pkg::median_noise_reduce_enable_off) begin
            rd_value[edge_color_pkg::enable_bit] = median_enable_reg;
        end else if (paddr == edge_color_pkg::highpass_shift_length_off) begin
            rd_value[edge_color_pkg::shift_width-1:0] = shift_reg;
        end else if (paddr >= edge_color_pkg::highpass_coef_r0c0_off
                     && coef_idx < 4'(edge_color_pkg::coef_count)
                     && paddr < edge_color_pkg::false_color_suppress_enable_off) begin
            rd_value[edge_color_pkg::coef_width-1:0] = coef_reg[coef_idx];
        end else if (paddr == edge_color_pkg::false_color_suppress_enable_off) begin
            rd_value[edge_color_pkg::enable_bit] = suppress_enable_reg;
        end else if (paddr == edge_color_pkg::suppress_detector_type_off) begin
            rd_value[edge_color_pkg::type_width-1:0] = det_type_reg;
        end else begin
            addr_hit = 1'b0;
        end
    end

    // handshake and read data capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= access && !pready;
            pslverr <= access && !pready && !addr_hit;
            if (access && !pready && !pwrite) begin
                prdata <= rd_value;
            end
        end
    end

    // configuration writes, taken on the completing edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_enable_reg     <= edge_color_pkg::enable_reset;
            median_enable_reg   <= edge_color_pkg::enable_reset;
            shift_reg           <= edge_color_pkg::shift_reset;
            suppress_enable_reg <= edge_color_pkg::enable_reset;
            det_type_reg        <= edge_color_pkg::type_reset;
            for (int i = 0; i < edge_color_pkg::coef_count; i++) begin
                coef_reg[i] <= edge_color_pkg::coef_reset;
            end
        end else if (wr_en && addr_hit) begin
            if (paddr == edge_color_pkg::edge_enhancer_enable_off) begin
                edge_enable_reg <= pwdata[edge_color_pkg::enable_bit];
            end
            if (paddr == edge_color_pkg::median_noise_reduce_enable_off) begin
                median_enable_reg <= pwdata[edge_color_pkg::enable_bit];
            end
            if (paddr == edge_color_pkg::highpass_shift_length_off) begin
                shift_reg <= pwdata[edge_color_pkg::shift_width-1:0];
            end
            if (paddr >= edge_color_pkg::highpass_coef_r0c0_off
                && paddr < edge_color_pkg::false_color_suppress_enable_off) begin
                coef_reg[coef_idx] <= pwdata[edge_color_pkg::coef_width-1:0];
            end
            if (paddr == edge_color_pkg::false_color_suppress_enable_off) begin
                suppress_enable_reg <= pwdata[edge_color_pkg::enable_bit];
            end
            if (paddr == edge_color_pkg::suppress_detector_type_off) begin
                det_type_reg <= pwdata[edge_color_pkg::type_width-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // line buffers and 3x3 window
    // ----------------------------------------------------------------
    edge_color_pkg::pixel_type line_a [0:LINE_WIDTH-1];
    edge_color_pkg::pixel_type line_b [0:LINE_WIDTH-1];
    edge_color_pkg::pixel_type win [0:2][0:2];
    logic [CW-1:0]             col_reg;
    logic                      accept;
    logic [LW-1:0]             fifo_level;

    assign accept = pix_in_valid && pix_in_ready;

    // column position wraps at the LINE_WIDTH parameter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            col_reg <= '0;
        end else if (accept) begin
            col_reg <= (col_reg == CW'(LINE_WIDTH-1)) ? '0 : col_reg + CW'(1);
        end
    end

    // two previous lines; row 0 oldest, row 2 the incoming line
    always_ff @(posedge pclk) begin
        if (accept) begin
            line_a[col_reg] <= pix_in;
            line_b[col_reg] <= line_a[col_reg];
            for (int r = 0; r < 3; r++) begin
                win[r][0] <= win[r][1];
                win[r][1] <= win[r][2];
            end
            win[0][2] <= line_b[col_reg];
            win[1][2] <= line_a[col_reg];
            win[2][2] <= pix_in;
        end
    end

    // ----------------------------------------------------------------
    // edge enhancer, median and detector arithmetic
    // ----------------------------------------------------------------
    logic signed [22:0] hpf_sum;
    logic signed [22:0] hpf_shifted;
    logic [7:0]         med_min;
    logic [7:0]         med_max;
    logic [7:0]         base_y;
    logic signed [23:0] luma_sum;
    logic [7:0]         luma_out;
    logic signed [11:0] horiz_det;
    logic signed [11:0] vert_det;
    logic signed [11:0] twod_det;
    logic signed [22:0] det_value;
    logic [22:0]        det_mag;
    logic               suppress_hit;

    // weighted neighbourhood sum, signed integer coefficients
    always_comb begin
        hpf_sum = '0;
        for (int r = 0; r < 3; r++) begin
            for (int c = 0; c < 3; c++) begin
                hpf_sum = hpf_sum + 23'($signed({1'b0, win[r][c].y}) * coef_reg[r*3+c]);
            end
        end
        hpf_shifted = hpf_sum >>> shift_reg;
    end

    // median of three along the centre row, a cheap impulse filter
    always_comb begin
        med_min = (win[1][0].y < win[1][1].y) ? win[1][0].y : win[1][1].y;
        med_max = (win[1][0].y < win[1][1].y) ? win[1][1].y : win[1][0].y;
        if (med_max > win[1][2].y) begin
            med_max = win[1][2].y;
        end
        base_y = median_enable_reg ? ((med_min > med_max) ? med_min : med_max) : win[1][1].y;
    end

    // add edge term and clamp; bypass passes the base luma
    always_comb begin
        luma_sum = $signed({16'h0000, base_y}) + 24'(hpf_shifted);
        if (!edge_enable_reg) begin
            luma_out = base_y;
        end else if (luma_sum < 0) begin
            luma_out = '0;
        end else if (luma_sum > $signed({16'h0000, edge_color_pkg::luma_max})) begin
            luma_out = edge_color_pkg::luma_max;
        end else begin
            luma_out = luma_sum[7:0];
        end
    end

    // detector sources; illegal types never trigger suppression
    always_comb begin
        horiz_det = 12'({win[1][1].y, 1'b0}) - 12'(win[1][0].y) - 12'(win[1][2].y);
        vert_det  = 12'({win[1][1].y, 1'b0}) - 12'(win[0][1].y) - 12'(win[2][1].y);
        twod_det  = 12'({win[1][1].y, 2'b00}) - 12'(win[0][1].y) - 12'(win[2][1].y)
                    - 12'(win[1][0].y) - 12'(win[1][2].y);
        det_value = '0;
        unique case (det_type_reg)
            edge_color_pkg::det_luma:      det_value = 23'(win[1][1].y);
            edge_color_pkg::det_horiz_hpf: det_value = 23'(horiz_det);
            edge_color_pkg::det_vert_hpf:  det_value = 23'(vert_det);
            edge_color_pkg::det_2d_hpf:    det_value = 23'(twod_det);
            edge_color_pkg::det_edge_hpf:  det_value = hpf_shifted;
            default:                       det_value = '0;
        endcase
        det_mag      = det_value[22] ? 23'(-det_value) : 23'(det_value);
        suppress_hit = suppress_enable_reg && (det_mag > 23'(SUPPRESS_LEVEL));
    end

    // ----------------------------------------------------------------
    // result stage into the output fifo
    // ----------------------------------------------------------------
    edge_color_pkg::pixel_type stage_reg;
    logic                      stage_valid_reg;
    logic                      window_ready_reg;
    logic                      fifo_ready;

    // ready keeps three slots spare: one stage word, one window word and one accept in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_in_ready <= 1'b0;
        end else begin
            pix_in_ready <= fifo_level < LW'(FIFO_DEPTH-3);
        end
    end

    // window is valid one cycle after an accept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            window_ready_reg <= 1'b0;
        end else begin
            window_ready_reg <= accept;
        end
    end

    // capture filtered pixel; chroma pulled to neutral on a hit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_valid_reg <= 1'b0;
            stage_reg       <= '0;
        end else if (window_ready_reg) begin
            stage_valid_reg <= 1'b1;
            stage_reg.y     <= luma_out;
            stage_reg.cb    <= suppress_hit ? edge_color_pkg::chroma_neutral : win[1][1].cb;
            stage_reg.cr    <= suppress_hit ? edge_color_pkg::chroma_neutral : win[1][1].cr;
        end else if (fifo_ready) begin
            stage_valid_reg <= 1'b0;
        end
    end

    stream_fifo #(
        .WIDTH ($bits(edge_color_pkg::pixel_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_out_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (stage_valid_reg),
        .in_ready  (fifo_ready),
        .in_data   (stage_reg),
        .out_valid (pix_out_valid),
        .out_ready (pix_out_ready),
        .out_data  (pix_out),
        .level     (fifo_level)
    );

endmodule

// *** testbench/edge_color_props.sv ***
// checker: apb timing, read-back widths and output hold of the edge/false colour slice
`timescale 1ns/1ns
module edge_color_props (
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [7:0]                paddr,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    input wire logic                      pix_out_valid,
    input wire logic                      pix_out_ready,
    input wire edge_color_pkg::pixel_type pix_out
);
    // ----------------------------------------------------------------
    // one clock domain, so clock and reset are given once
    // ----------------------------------------------------------------
    default clocking cb_main @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready_wait; psel && penable && !pready |=> pready; endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("pready late");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_ready_cause; pready |-> psel && penable && $past(penable); endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
    property p_err_map; pready && (paddr[1:0] != 2'h0 || paddr > 8'h34) |-> pslverr; endproperty
    a_err_map: assert property (p_err_map) else $error("bad address not refused");
    property p_err_only; pslverr |-> pready; endproperty
    a_err_only: assert property (p_err_only) else $error("pslverr outside pready");
    // reserved bits read zero on every mapped register
    property p_rd_en; pready && !pwrite && (paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h30)
        |-> prdata[31:1] == 31'h0; endproperty
    a_rd_en: assert property (p_rd_en) else $error("enable reads wide");
    property p_rd_shf; pready && !pwrite && paddr == 8'h08 |-> prdata[31:4] == 28'h0; endproperty
    a_rd_shf: assert property (p_rd_shf) else $error("shift reads wide");
    property p_rd_coef; pready && !pwrite && paddr >= 8'h0c && paddr <= 8'h2c && paddr[1:0] == 2'h0
        |-> prdata[31:10] == 22'h0; endproperty
    a_rd_coef: assert property (p_rd_coef) else $error("coefficient reads wide");
    property p_rd_typ; pready && !pwrite && paddr == 8'h34 |-> prdata[31:3] == 29'h0; endproperty
    a_rd_typ: assert property (p_rd_typ) else $error("type reads wide");
    // a stalled head must not move or vanish
    property p_out_hold; pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(pix_out); endproperty
    a_out_hold: assert property (p_out_hold) else $error("output pixel changed while stalled");
endmodule

bind edge_color_filter edge_color_props chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready), .pix_out(pix_out));

// *** testbench/pixel_sink.sv ***
// partner: following pipeline stage that takes pixels with random stalls
`timescale 1ns/1ns
module pixel_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hold,
    output logic     pix_out_ready
);
    // registered ready; hold forces a full stall so the fifo fills up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_out_ready <= 1'b0;
        end else begin
            pix_out_ready <= !hold && ($urandom % 4 != 0);
        end
    end
endmodule

// *** testbench/testbench.sv ***
// testbench: apb register checks and pixel runs against the edge/false colour slice
`timescale 1ns/1ns
module testbench;
    localparam int         lw      = 8;
    localparam logic [8:0] sup_lvl = 9'h040;
    logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, sink_hold, rd_err;
    logic                      pix_in_valid, pix_in_ready, pix_out_valid, pix_out_ready;
    logic [7:0]                paddr;
    logic [31:0]               pwdata, prdata, rd_data, wv [14];
    edge_color_pkg::pixel_type pix_in, pix_out, out_q [$];
    int                        error_cnt, checked, cyc, coef [9], shift_amount, detector_type_field;
    logic                      en, med, false_color_suppression;
    logic [7:0]                yv [lw];

    edge_color_filter #(.LINE_WIDTH(lw), .FIFO_DEPTH(16), .SUPPRESS_LEVEL(sup_lvl)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_in_valid(pix_in_valid),
        .pix_in_ready(pix_in_ready), .pix_in(pix_in), .pix_out_valid(pix_out_valid),
        .pix_out_ready(pix_out_ready), .pix_out(pix_out));
    pixel_sink sink (.pclk(pclk), .presetn(presetn), .hold(sink_hold), .pix_out_ready(pix_out_ready));

    // ----------------------------------------------------------------
    // clock, timeout and output capture
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // runs take about a thousand cycles; a hang ends the run as a mismatch
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    always @(posedge pclk) begin
        if (pix_out_valid === 1'b1 && pix_out_ready === 1'b1) out_q.push_back(pix_out);
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_pix(input edge_color_pkg::pixel_type got, input edge_color_pkg::pixel_type exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // setup on the next edge, hold until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic feed(input edge_color_pkg::pixel_type p);
        pix_in_valid <= 1'b1;
        pix_in <= p;
        do @(posedge pclk); while (pix_in_ready !== 1'b1);
    endtask

    function automatic logic [31:0] reg_mask(input int i);
        if (i < 2 || i == 12) return 32'h1;
        if (i == 2) return 32'hf;
        if (i == 13) return 32'h7;
        return 32'h3ff;
    endfunction

    // every line repeats one column pattern, so tap column c of output k sees pattern column k+c-2
    function automatic edge_color_pkg::pixel_type exp_pix(input int k, input logic [7:0] cb, input logic [7:0] cr);
        int                        s, h, y, d, p [3];
        edge_color_pkg::pixel_type r;
        foreach (p[c]) p[c] = int'(yv[(k + c + lw - 2) % lw]);
        s = 0;
        foreach (coef[i]) s += coef[i] * p[i % 3];
        h = s >>> shift_amount;
        y = !med ? p[1] : ((p[0] > p[1]) ^ (p[0] > p[2])) ? p[0] : ((p[1] > p[0]) ^ (p[1] > p[2])) ? p[1] : p[2];
        y = en ? y + h : y;
        y = (y < 0) ? 0 : (y > 255) ? 255 : y;
        d = (detector_type_field == 0) ? p[1] : (detector_type_field == 4) ? h : (detector_type_field == 1 || detector_type_field == 3) ? 2 * p[1] - p[0] - p[2] : 0;
        d = (d < 0) ? -d : d;
        r.y = y[7:0];
        r.cb = (false_color_suppression && d > int'(sup_lvl)) ? edge_color_pkg::chroma_neutral : cb;
        r.cr = (false_color_suppression && d > int'(sup_lvl)) ? edge_color_pkg::chroma_neutral : cr;
        return r;
    endfunction

    task automatic run_cfg(input int t);
        logic [7:0]                cb, cr;
        detector_type_field = (t < 6) ? t : 0;
        en = (t != 1);
        med = (t % 2 == 1);
        false_color_suppression = (t != 6);
        shift_amount = (t == 3) ? 15 : $urandom_range(7, 15);
        foreach (coef[i]) coef[i] = $urandom_range(0, 15) - 8;
        foreach (yv[i]) yv[i] = 8'($urandom_range(100, 255));
        cb = 8'($urandom());
        cr = 8'($urandom());
        apb(1'b1, edge_color_pkg::edge_enhancer_enable_off, {31'h0, en});
        apb(1'b1, edge_color_pkg::median_noise_reduce_enable_off, {31'h0, med});
        apb(1'b1, edge_color_pkg::highpass_shift_length_off, 32'(shift_amount));
        for (int i = 0; i < 9; i++) apb(1'b1, 8'(12 + 4 * i), 32'(coef[i]));
        apb(1'b1, edge_color_pkg::false_color_suppress_enable_off, {31'h0, false_color_suppression});
        apb(1'b1, edge_color_pkg::suppress_detector_type_off, 32'(detector_type_field));
        out_q.delete();
        sink_hold <= (t == 2);
        fork
            for (int k = 0; k < 4 * lw; k++) feed({yv[k % lw], cb, cr});
            if (t == 2) begin
                repeat (40) @(posedge pclk);
                check_word({31'h0, pix_in_ready}, 32'h0);
                sink_hold <= 1'b0;
            end
        join
        pix_in_valid <= 1'b0;
        while (out_q.size() < 4 * lw) @(posedge pclk);
        // early outputs still hold stale line data, only the settled last line is judged
        for (int k = 3 * lw; k < 4 * lw; k++) check_pix(out_q[k], exp_pix(k, cb, cr));
        $display("test cfg %0d done, mismatches %0d", t, error_cnt);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(88650));
        {error_cnt, checked, cyc} = '0;
        {psel, penable, pwrite, pix_in_valid, sink_hold, presetn} = '0;
        {paddr, pwdata, pix_in} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check_word(rd_data, 32'h0);
        end
        for (int i = 0; i < 14; i++) begin
            wv[i] = $urandom();
            apb(1'b1, 8'(4 * i), wv[i]);
            apb(1'b0, 8'(4 * i), 32'h0);
            check_word(rd_data, wv[i] & reg_mask(i));
        end
        apb(1'b0, 8'h38, 32'h0);
        check_word({31'h0, rd_err}, 32'h1);
        check_word(rd_data, 32'h0);
        apb(1'b1, 8'h05, 32'hffffffff);
        check_word({31'h0, rd_err}, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        check_word(rd_data, wv[1] & 32'h1);
        $display("test registers done, mismatches %0d", error_cnt);
        for (int t = 0; t < 7; t++) run_cfg(t);
        stop_test();
    end
endmodule
